// [iqm_pkg.sv]
package iqm_pkg;

  // Register byte addresses on the plain register port
  localparam logic [7:0] ADDR_BAND_SEL = 8'hc2;
  localparam logic [7:0] ADDR_RAM_WORD = 8'hc9;
  localparam logic [7:0] ADDR_RAM_ADDR = 8'hca;
  localparam logic [7:0] ADDR_TX_BYTE = 8'hcb;
  localparam logic [7:0] ADDR_PHASE_STEP = 8'hd1;
  localparam logic [7:0] ADDR_SCALE = 8'hd2;
  localparam logic [7:0] ADDR_CONTROL = 8'hd3;
  localparam logic [7:0] ADDR_STATE = 8'heb;

  // Field positions
  localparam int BAND_BIT = 7;
  localparam int CTRL_POLARITY_BIT = 5;
  localparam int CTRL_ENABLE_BIT = 4;
  localparam int CTRL_ASK_BIT = 3;
  localparam int CTRL_LOAD_BIT = 2;
  localparam int CTRL_SHIFT_BIT = 1;
  localparam int STATE_BUSY_BIT = 7;
  localparam int STATE_FIXED_BIT = 6;

  // Values after reset
  localparam logic BAND_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam logic [11:0] PHASE_RESET = 12'h000;

  // Phase and wave constants
  localparam logic [11:0] QUARTER_TURN = 12'h400;
  localparam logic [3:0] BITS_PER_BYTE_M1 = 4'h7;
  localparam int ROM_ENTRIES = 128;

  // Quarter-wave sine table: 128 magnitudes of 8 bits, built at elaboration
  function automatic logic [1023:0] build_quarter_rom();
    logic [1023:0] t;
    longint x;
    longint x2;
    longint x3;
    longint x5;
    longint x7;
    longint s;
    longint m;
    int i;
    t = '0;
    for (i = 0; i < ROM_ENTRIES; i++) begin
      // Sample at the middle of each step, angle in Q16
      x = (longint'(2 * i + 1) * 205887) / 512;
      x2 = (x * x) >>> 16;
      x3 = (x * x2) >>> 16;
      x5 = (x3 * x2) >>> 16;
      x7 = (x5 * x2) >>> 16;
      s = x - x3 / 6 + x5 / 120 - x7 / 5040;
      m = (s * 255 + 32768) >>> 16;
      if (m > 255) begin
        m = 255;
      end
      t[8*i +: 8] = m[7:0];
    end
    return t;
  endfunction

  localparam logic [1023:0] QUARTER_ROM = build_quarter_rom();

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iqm_req_t;

  // One I/Q sample pair for the DACs
  typedef struct packed {
    logic signed [8:0] i_word;
    logic signed [8:0] q_word;
  } iqm_sample_t;

endpackage

// [iqm_modulator.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// [R1] All logic runs on the baseband clock
// [R2] Waveform only while modulation enable set
// [R3] 9-bit I/Q from quarter-wave ROM, unfolded
// [R4] Phase advances four times offset per clock
// [R5] FSK step adds RAM word to offset for one bits, subtracts it for zero bits
// [R6] 64 by 8 transmit RAM, 6-bit address
// [R7] Software fills RAM uniformly for ASK
// [R8] Bit spans address count, each scale clocks
// [R9] Bit rate halves: addresses swept twice
// [R10] Polarity swaps I/Q, selects sideband
// [R11] Mode bit: one ASK, zero FSK
// [R12] Band bit picks divider, resets to one
// [R13] RAM writes only in load mode
// [R14] Byte buffer shifts only when enabled
// [R15] Busy flag low when byte may load
// [R16] Bits sent MSB first, one per period
module iqm_modulator (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire iqm_pkg::iqm_req_t reg_req,
  output logic [7:0] reg_rdata,
  // DAC and carrier outputs
  output iqm_pkg::iqm_sample_t dac,
  output logic carrier_band_315
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic band;               // Carrier divider select
    logic [7:0] phase_step;   // Baseband frequency offset
    logic [7:0] scale;        // Clocks per RAM address
    logic [5:0] ram_addr;     // Write pointer or addresses per bit
    logic polarity;           // Lower sideband when set
    logic mod_en;             // Modulation active
    logic ask_mode;           // ASK when set, FSK when clear
    logic load_mode;          // RAM load access
    logic shift_en;           // Byte buffer may shift
    logic [7:0] hold;         // Byte waiting to be sent
    logic hold_full;          // Busy flag
    logic [7:0] shreg;        // Bits still to send
    logic [3:0] bits_left;    // Bits left in shreg
    logic bit_active;         // A data bit is on air
    logic cur_bit;            // Value of the bit on air
    logic [11:0] phase;       // Phase accumulator
    logic [7:0] clk_cnt;      // Clocks spent on this address
    logic [6:0] slot;         // Address slot inside the bit
    logic [63:0][7:0] ram;    // Transmit RAM
    logic [7:0] rdata;        // Read data, one cycle late
    logic signed [8:0] i_out; // I sample
    logic signed [8:0] q_out; // Q sample
    logic band_out;           // Band select to the PLL divider
  } iqm_state_t;

  iqm_state_t st_reg;
  iqm_state_t st_next;

  // Helper values of the datapath
  logic [7:0] scale_eff;
  logic [5:0] nbits_eff;
  logic [6:0] last_slot;
  logic [6:0] mirror;
  logic [5:0] ram_idx;
  logic [7:0] word;
  logic [11:0] base_step;
  logic [11:0] step;
  logic bit_edge;
  logic gate;
  logic signed [8:0] sin_s;
  logic signed [8:0] cos_s;

  ////////////////////////////////////////////////////////////////////////
  // Quarter-wave unfold: upper phase bits pick mirror and sign
  function automatic logic signed [8:0] wave(input logic [11:0] p);
    logic [6:0] idx;
    logic [7:0] mag;
    idx = p[10] ? ~p[9:3] : p[9:3]; // [R3]
    mag = iqm_pkg::QUARTER_ROM[8*idx +: 8];
    wave = p[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    // Zero settings would stall the sequencer, so they count as one
    scale_eff = (st_reg.scale == 8'h00) ? 8'h01 : st_reg.scale;
    nbits_eff = (st_reg.ram_addr == 6'h00) ? 6'h01 : st_reg.ram_addr;
    last_slot = {nbits_eff, 1'b0} - 7'h01;
    // Sweep up then down, so each bit spends twice the address count
    mirror = last_slot - st_reg.slot; // [R9]
    ram_idx = (st_reg.slot < {1'b0, nbits_eff}) ? st_reg.slot[5:0] : mirror[5:0]; // [R8]
    word = st_reg.ram[ram_idx]; // [R6]
    base_step = {2'h0, st_reg.phase_step, 2'h0}; // [R4]
    if (st_reg.ask_mode) begin
      step = base_step + {4'h0, word};
    end else if (st_reg.cur_bit) begin
      step = base_step + {4'h0, word}; // [R5]
    end else begin
      // Zero bits deviate below the centre tone
      step = base_step - {4'h0, word};
    end
    bit_edge = 1'b0;
    // ASK keys the carrier off for zero bits and idle time
    gate = st_reg.ask_mode ? (st_reg.bit_active & st_reg.cur_bit) : 1'b1; // [R11]
    sin_s = wave(st_reg.phase);
    cos_s = wave(st_reg.phase + iqm_pkg::QUARTER_TURN);

    // Sequencer and waveform
    if (!st_reg.mod_en) begin
      // Inactive: outputs quiet and sequencing parked
      st_next.phase = iqm_pkg::PHASE_RESET; // [R2]
      st_next.clk_cnt = 8'h00;
      st_next.slot = 7'h00;
      st_next.bit_active = 1'b0;
      st_next.cur_bit = 1'b0;
      st_next.bits_left = 4'h0;
      st_next.i_out = '0;
      st_next.q_out = '0;
    end else begin
      st_next.phase = st_reg.phase + step; // [R4]
      if (!gate) begin
        st_next.i_out = '0;
        st_next.q_out = '0;
      end else if (st_reg.polarity) begin
        st_next.i_out = sin_s; // [R10]
        st_next.q_out = cos_s;
      end else begin
        st_next.i_out = cos_s; // [R10]
        st_next.q_out = sin_s;
      end
      // RAM sequencing is held while software loads the RAM
      if (!st_reg.load_mode) begin
        if (st_reg.clk_cnt >= scale_eff - 8'h01) begin
          st_next.clk_cnt = 8'h00; // [R8]
          if (st_reg.slot >= last_slot) begin
            st_next.slot = 7'h00;
            bit_edge = 1'b1;
          end else begin
            st_next.slot = st_reg.slot + 7'h01;
          end
        end else begin
          st_next.clk_cnt = st_reg.clk_cnt + 8'h01;
        end
      end
      // Bit boundary: next bit, MSB first
      if (bit_edge) begin
        if (st_reg.bits_left != 4'h0) begin
          st_next.cur_bit = st_reg.shreg[7]; // [R16]
          st_next.shreg = {st_reg.shreg[6:0], 1'b0};
          st_next.bits_left = st_reg.bits_left - 4'h1;
          st_next.bit_active = 1'b1;
        end else if (st_reg.hold_full && st_reg.shift_en) begin
          st_next.cur_bit = st_reg.hold[7]; // [R16]
          st_next.shreg = {st_reg.hold[6:0], 1'b0};
          st_next.bits_left = iqm_pkg::BITS_PER_BYTE_M1;
          st_next.bit_active = 1'b1;
          st_next.hold_full = 1'b0; // [R14]
        end else begin
          st_next.cur_bit = 1'b0;
          st_next.bit_active = 1'b0;
        end
      end
    end

    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        iqm_pkg::ADDR_BAND_SEL: begin
          st_next.band = reg_req.wdata[iqm_pkg::BAND_BIT]; // [R12]
        end
        iqm_pkg::ADDR_TX_BYTE: begin
          // A byte written while busy is dropped; software polls first
          if (!st_reg.hold_full) begin
            st_next.hold = reg_req.wdata; // [R15]
            st_next.hold_full = 1'b1;
          end
        end
        iqm_pkg::ADDR_PHASE_STEP: begin
          st_next.phase_step = reg_req.wdata;
        end
        iqm_pkg::ADDR_SCALE: begin
          st_next.scale = reg_req.wdata;
        end
        iqm_pkg::ADDR_CONTROL: begin
          st_next.polarity = reg_req.wdata[iqm_pkg::CTRL_POLARITY_BIT];
          st_next.mod_en = reg_req.wdata[iqm_pkg::CTRL_ENABLE_BIT];
          st_next.ask_mode = reg_req.wdata[iqm_pkg::CTRL_ASK_BIT];
          st_next.load_mode = reg_req.wdata[iqm_pkg::CTRL_LOAD_BIT];
          st_next.shift_en = reg_req.wdata[iqm_pkg::CTRL_SHIFT_BIT];
        end
        iqm_pkg::ADDR_RAM_WORD: begin
          if (st_reg.load_mode) begin
            st_next.ram[st_reg.ram_addr] = reg_req.wdata; // [R13]
          end
        end
        iqm_pkg::ADDR_RAM_ADDR: begin
          // Same field is the write pointer and the per-bit address count
          if (st_reg.load_mode) begin
            st_next.ram_addr = reg_req.wdata[5:0]; // [R13]
          end
        end
        default: begin
          // Other addresses ignore writes
        end
      endcase
    end

    // Register reads: only the state register shows anything
    if (reg_req.rd) begin
      case (reg_req.addr)
        iqm_pkg::ADDR_STATE: begin
          st_next.rdata[iqm_pkg::STATE_BUSY_BIT] = st_reg.hold_full; // [R15]
          st_next.rdata[iqm_pkg::STATE_FIXED_BIT] = 1'b1;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    st_next.band_out = st_next.band;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register on the baseband clock
  always_ff @(posedge sys_clk or posedge rst) begin // [R1]
    if (rst) begin
      st_reg <= '0;
      st_reg.band <= iqm_pkg::BAND_RESET; // [R12]
      st_reg.band_out <= iqm_pkg::BAND_RESET;
      st_reg.hold <= iqm_pkg::BYTE_RESET;
      st_reg.ram_addr <= iqm_pkg::ADDR_RESET;
      st_reg.phase <= iqm_pkg::PHASE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign reg_rdata = st_reg.rdata;
  assign dac.i_word = st_reg.i_out;
  assign dac.q_word = st_reg.q_out;
  assign carrier_band_315 = st_reg.band_out;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_disabled_quiet: assert property (!st_reg.mod_en ##1 !st_reg.mod_en |=> dac.i_word == 0 && dac.q_word == 0) // [R2]
    else $error("samples not zero while modulation disabled");

  // The step used is the one registered in the launching cycle, so a same-cycle offset write is harmless
  a_ask_step: assert property (st_reg.mod_en && st_reg.ask_mode |=>
    st_reg.phase == $past(st_reg.phase) + {2'h0, $past(st_reg.phase_step), 2'h0} + {4'h0, $past(word)}) // [R4]
    else $error("phase step differs from offset plus word");

  a_fsk_deviation: assert property (st_reg.mod_en && !st_reg.ask_mode && st_reg.cur_bit
    |=> st_reg.phase - $past(st_reg.phase) == {2'h0, $past(st_reg.phase_step), 2'h0} + {4'h0, $past(word)}) // [R5]
    else $error("fsk step wrong");

  a_ram_guard: assert property (reg_req.wr && reg_req.addr == iqm_pkg::ADDR_RAM_ADDR && !st_reg.load_mode
    |=> $stable(st_reg.ram_addr)) // [R13]
    else $error("ram address written outside load mode");

  a_ram_range: assert property (st_reg.mod_en |-> ram_idx < nbits_eff) // [R8]
    else $error("ram index beyond per-bit address count");

  a_busy_set: assert property (reg_req.wr && reg_req.addr == iqm_pkg::ADDR_TX_BYTE && !st_reg.hold_full
    |=> st_reg.hold_full ##0 reg_rdata == 8'h00) // [R15]
    else $error("busy not set after byte load");

  a_busy_read: assert property (reg_req.rd && reg_req.addr == iqm_pkg::ADDR_STATE
    |=> reg_rdata == {$past(st_reg.hold_full), 7'h40}) // [R15]
    else $error("state read wrong");

  a_shift_gate: assert property (st_reg.hold_full && !st_reg.shift_en && !reg_req.wr |=> st_reg.hold_full) // [R14]
    else $error("byte consumed while shift disabled");

  a_msb_first: assert property (bit_edge && st_reg.bits_left == 0 && st_reg.hold_full && st_reg.shift_en
    |=> st_reg.cur_bit == $past(st_reg.hold[7]) && st_reg.bits_left == 4'h7) // [R16]
    else $error("first bit not msb");

  a_ask_off: assert property (st_reg.mod_en && st_reg.ask_mode && !st_reg.cur_bit
    |=> dac.i_word == 0 && dac.q_word == 0) // [R11]
    else $error("ask zero bit not keyed off");

  a_band_out: assert property (reg_req.wr && reg_req.addr == iqm_pkg::ADDR_BAND_SEL
    |=> carrier_band_315 == $past(reg_req.wdata[7])) // [R12]
    else $error("band select not applied");

  a_polarity_swap: assert property (st_reg.mod_en && st_reg.polarity && gate |=> dac.i_word == $past(sin_s)) // [R10]
    else $error("polarity did not swap I and Q");

  c_byte_taken: cover property (bit_edge && st_reg.hold_full && st_reg.shift_en);
  c_ask_on: cover property (st_reg.ask_mode && st_reg.cur_bit && st_reg.bit_active);
  c_lower_side: cover property (st_reg.mod_en && st_reg.polarity && !st_reg.ask_mode);
  c_ram_load: cover property (reg_req.wr && reg_req.addr == iqm_pkg::ADDR_RAM_WORD && st_reg.load_mode);

endmodule

// [iqm_dac_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural stand-in for the I and Q converters in front of the mixer
module iqm_dac_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sample stream from the modulator
  input wire iqm_pkg::iqm_sample_t dac,
  // Observation
  output logic active,
  output logic signed [8:0] i_level,
  output logic signed [8:0] q_level
);
  // A carrier is present whenever either converter sees a non-zero code
  assign active = (dac.i_word != 9'sh000) || (dac.q_word != 9'sh000);

  // Converters latch each code on the sampling edge, like a real track stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Outputs park at mid-scale while held in reset
      i_level <= 9'sh000;
      q_level <= 9'sh000;
    end else begin
      i_level <= dac.i_word;
      q_level <= dac.q_word;
    end
  end
endmodule

// [iqm_modulator_tb.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Compare two values, count and report a mismatch
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end

module iqm_modulator_tb;
  // Clock, reset and register port
  logic sys_clk;
  logic rst;
  iqm_pkg::iqm_req_t req;
  logic [7:0] reg_rdata;
  iqm_pkg::iqm_sample_t dac;
  logic band_315;
  logic act;
  // Bookkeeping
  int bad_count;
  int n_tests;
  // Phase step used by the wave checks: four times 65 minus word 28
  localparam int STEP = 232;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  iqm_modulator i_iqm_modulator (.sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
    .dac(dac), .carrier_band_315(band_315));
  iqm_dac_model i_iqm_dac_model (.sys_clk(sys_clk), .rst(rst), .dac(dac), .active(act),
    .i_level(), .q_level());

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Ideal sine of the middle of the 8-step phase bucket, scaled to 255
  function automatic int wave(input int ph);
    real v;
    v = 255.0 * $sin(6.283185307 * real'(((ph % 4096) / 8) * 8 + 4) / 4096.0);
    return int'(v);
  endfunction

  // Table rounding may differ from the ideal curve by one code
  task automatic near(input logic signed [8:0] got, input int e);
    `CHK(($signed(got) - e <= 1) && (e - $signed(got) <= 1), 1'b1)
  endtask

  // Restart the carrier in FSK idle and follow the phase sample by sample
  task automatic run_wave(input logic pol);
    int ph;
    int k;
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(dac, 18'h00000)
    wr_reg(iqm_pkg::ADDR_CONTROL, {2'b00, pol, 5'b10000});
    #1;
    k = 0;
    // First non-zero sample is phase zero after the restart
    while (!act && k < 8) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    ph = 0;
    for (k = 0; k < 12; k++) begin
      near(dac.i_word, pol ? wave(ph) : wave(ph + 1024));
      near(dac.q_word, pol ? wave(ph + 1024) : wave(ph));
      ph = (ph + STEP) % 4096;
      @(posedge sys_clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    logic act_log [0:199];
    int f;
    int k;
    rst = 1'b1;
    req = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset state, status read and write-only reads
    #1 `CHK(band_315, 1'b1)
    rd_reg(iqm_pkg::ADDR_STATE, d);
    `CHK(d, 8'h40)
    rd_reg(iqm_pkg::ADDR_PHASE_STEP, d);
    `CHK(d, 8'h00)
    // Band bit both ways, unmapped write leaves it alone
    wr_reg(iqm_pkg::ADDR_BAND_SEL, 8'h00);
    #1 `CHK(band_315, 1'b0)
    wr_reg(iqm_pkg::ADDR_BAND_SEL, 8'h80);
    wr_reg(8'h00, 8'h00);
    #1 `CHK(band_315, 1'b1)
    // Load word 28 at slot 0 with one address per bit
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h04);
    wr_reg(iqm_pkg::ADDR_RAM_ADDR, 8'h00);
    wr_reg(iqm_pkg::ADDR_RAM_WORD, 8'd28);
    // Outside load mode these must be dropped, else the step would change
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(iqm_pkg::ADDR_RAM_WORD, 8'd100);
    wr_reg(iqm_pkg::ADDR_RAM_ADDR, 8'h05);
    wr_reg(iqm_pkg::ADDR_SCALE, 8'h01);
    wr_reg(iqm_pkg::ADDR_PHASE_STEP, 8'd65);
    // Both sidebands
    run_wave(1'b0);
    run_wave(1'b1);
    // ASK: uniform words over two addresses, four clocks each
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h04);
    for (k = 0; k < 2; k++) begin
      wr_reg(iqm_pkg::ADDR_RAM_ADDR, 8'(k));
      wr_reg(iqm_pkg::ADDR_RAM_WORD, 8'd28);
    end
    wr_reg(iqm_pkg::ADDR_RAM_ADDR, 8'h02);
    wr_reg(iqm_pkg::ADDR_SCALE, 8'h04);
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h18);
    wr_reg(iqm_pkg::ADDR_TX_BYTE, 8'ha5);
    // Shifting held off: byte stays pending and the carrier stays off
    f = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      #1 f = f + int'(act);
    end
    `CHK(f, 0)
    rd_reg(iqm_pkg::ADDR_STATE, d);
    `CHK(d, 8'hc0)
    // Release the shifter and record the on/off envelope
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h1a);
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      #1 act_log[k] = act;
    end
    f = -1;
    for (k = 0; k < 200; k++) begin
      if (f < 0 && act_log[k]) begin
        f = k;
      end
    end
    `CHK(f >= 0 && f < 60, 1'b1)
    if (f >= 0 && f < 60) begin
      // Each bit lasts 2 x 2 addresses x 4 clocks, MSB first
      for (k = 0; k < 128; k++) begin
        `CHK(act_log[f + k], 8'ha5 >> (7 - k / 16) & 8'h01 ? 1'b1 : 1'b0)
      end
      `CHK(act_log[f + 128], 1'b0)
    end
    rd_reg(iqm_pkg::ADDR_STATE, d);
    `CHK(d, 8'h40)
    // FSK with a byte of ones: carrier never keys off, byte leaves the buffer
    wr_reg(iqm_pkg::ADDR_CONTROL, 8'h12);
    wr_reg(iqm_pkg::ADDR_TX_BYTE, 8'hff);
    f = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      #1 f = f + int'(act);
    end
    `CHK(f, 40)
    rd_reg(iqm_pkg::ADDR_STATE, d);
    `CHK(d, 8'h40)
    end_sim();
  end
endmodule
